/* File: hw/drive_input_terminal_functions.sv */
// Local design decisions: the Wishbone slave port and the placing of the registers.
`timescale 1ns/10ps
// What this block does
// - Bypass rising edge suppresses motor output
// - Bypass falling edge: wait delay, match, run
// - Match only above configured frequency threshold
// - Run at power-on raises unattended-start error
// - Lock rejects edits, frequency maybe exempt
// - Lock released: all edits accepted again
// - Lock scope decides frequency editability
// - Software lock works without lock terminal
// - Select on, pair 00: current loop source
// - Select on, pair 01: second voltage source
// - Select off: primary voltage source for either pair
// - Only voltage inputs may be bipolar
// - Selection only when frequency source is 01
// - Reset pulse: output off, restart, clear trip
// - Alarm drops within 30 ms of reset
// - Reset edge selectable, active-high only
// - Power-on runs the reset sequence
// - Reset held 4 s at power-up: comm error
// - Over-temperature trips with thermistor code
// - Open thermistor trips; key clears when cool
module drive_input_terminal_functions
	import drive_terminal_pkg::*;
#(
	parameter int FREQ_W = 16,
	parameter int MS_CYCLES = MS_TICK_CYCLES,
	parameter int DEBOUNCE_COUNT = DEBOUNCE_CYCLES
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Intelligent input terminals
	input wire logic bypass_enable_in,
	input wire logic edit_lock_in,
	input wire logic analog_select_in,
	input wire logic reset_in,
	input wire logic forward_run_in,
	input wire logic reverse_run_in,
	// Thermistor comparator results from the analog front end
	input wire logic thermistor_in,
	input wire logic thermistor_open_i,
	// Operator keys and sensed motor frequency
	input wire logic stop_reset_key_i,
	input wire logic any_key_i,
	input wire logic [FREQ_W-1:0] motor_freq_i,
	// Parameter edit requests
	input wire logic edit_req_i,
	input wire logic edit_is_freq_i,
	output logic edit_accept_o,
	output logic edit_reject_o,
	// Drive control outputs
	output logic motor_output_o,
	output logic run_mode_o,
	output logic freq_match_o,
	output logic alarm_o,
	output logic [7:0] trip_code_o,
	output logic comm_error_o,
	// Analog front end selection
	output logic [1:0] analog_source_o,
	output logic range_4_20_o,
	output logic bipolar_enable_o
);
	localparam int MW = $clog2(MS_CYCLES + 1);
	localparam logic [MW-1:0] MS_LAST = MW'(MS_CYCLES - 1);

	state_type state;
	state_type next_state;
	logic [8:0] config_reg;
	logic [15:0] retry_delay_param;
	logic [15:0] match_threshold_param;
	logic [7:0] trip_code;
	logic [7:0] next_trip_code;
	logic [MW-1:0] ms_div;
	logic ms_tick;
	logic [15:0] state_ms;
	logic [12:0] comm_ms;
	logic powerup_pending;
	logic powerup_window;
	logic comm_err;
	logic [TERMINALS-1:0] term_level;
	logic [TERMINALS-1:0] term_rise;
	logic [TERMINALS-1:0] term_fall;

	// Merge a 32-bit write into a register under the byte selects
	function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] data,
			input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				res[8*b +: 8] = data[8*b +: 8];
			end
		end
		return res;
	endfunction

	// Filtered terminals
	terminal_debounce #(
		.WIDTH(TERMINALS),
		.COUNT(DEBOUNCE_COUNT)
	) debounce_inst (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.raw_i({thermistor_open_i, thermistor_in, reverse_run_in, forward_run_in,
			reset_in, analog_select_in, edit_lock_in, bypass_enable_in}),
		.level_o(term_level),
		.rise_o(term_rise),
		.fall_o(term_fall)
	);

	// Configuration fields
	wire [1:0] lock_scope_param = config_reg[CFG_LOCK_LSB +: 2];
	wire [1:0] input_pair_param = config_reg[CFG_PAIR_LSB +: 2];
	wire [1:0] bipolar_mode_param = config_reg[CFG_BIPOLAR_LSB +: 2];
	wire [1:0] freq_source_param = config_reg[CFG_FSRC_LSB +: 2];
	wire reset_edge_param = config_reg[CFG_RESET_EDGE_BIT];

	// Terminal decode; the reset terminal is used as normally open only
	wire run_cmd = term_level[T_FWD] | term_level[T_REV];
	wire reset_level = term_level[T_RESET];
	wire reset_event = reset_edge_param ? term_fall[T_RESET] : term_rise[T_RESET];
	wire therm_fault = term_level[T_TH_OVER] | term_level[T_TH_OPEN];
	wire retry_done = ms_tick && (state_ms >= retry_delay_param);
	wire hold_done = ms_tick && (state_ms >= RESET_HOLD_MS);
	wire above_threshold = motor_freq_i > match_threshold_param;

	// Edit lock decode
	wire soft_lock = lock_scope_param[1];
	wire lock_active = soft_lock | term_level[T_LOCK];
	wire freq_exempt = lock_scope_param[0];
	wire edit_ok = ~lock_active | (edit_is_freq_i & freq_exempt);

	// Analog source decode
	wire analog_ref = freq_source_param == FSRC_ANALOG;
	wire [1:0] pair_source = (input_pair_param == PAIR_CURRENT) ? SRC_CURRENT :
		(input_pair_param == PAIR_SECOND_V) ? SRC_SECOND_V : SRC_PRIMARY_V;
	wire [1:0] sel_source = term_level[T_ASEL] ? pair_source : SRC_PRIMARY_V;
	wire [1:0] next_source = analog_ref ? sel_source : SRC_NONE;
	wire next_bipolar = (next_source == SRC_PRIMARY_V || next_source == SRC_SECOND_V) &&
		(bipolar_mode_param != BIPOLAR_OFF);

	// Bus decode
	wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire bus_wr = bus_req & wb_we_i;
	wire [31:0] status_word = {10'h000, comm_err, lock_active, analog_source_o, alarm_o,
		motor_output_o, trip_code, 5'h00, state};
	wire [31:0] read_word = (wb_adr_i == CONFIG_ADDR) ? {23'h000000, config_reg} :
		(wb_adr_i == RETRY_ADDR) ? {16'h0000, retry_delay_param} :
		(wb_adr_i == THRESH_ADDR) ? {16'h0000, match_threshold_param} :
		(wb_adr_i == STATUS_ADDR) ? status_word : 32'h00000000;
	wire [31:0] write_word = merge_bytes(read_word, wb_dat_i, wb_sel_i); // New data under sel, old value elsewhere

	// Run/trip sequencing; a recognised reset edge outranks everything
	always_comb begin
		next_state = state;
		next_trip_code = trip_code;
		if (reset_event) begin
			next_state = ST_RESET;
			next_trip_code = TRIP_NONE;
		end else if (therm_fault && state != ST_TRIP && state != ST_RESET) begin
			next_state = ST_TRIP;
			next_trip_code = THERMISTOR_TRIP_CODE;
		end else begin
			case (state)
				ST_RESET: begin
					if (hold_done) begin
						if (powerup_pending && run_cmd) begin
							next_state = ST_TRIP;
							next_trip_code = UNATTENDED_START_CODE;
						end else begin
							next_state = ST_STOP;
						end
					end
				end
				ST_STOP: begin
					if (term_rise[T_BYPASS]) begin
						next_state = ST_BYPASS;
					end else if (run_cmd) begin
						next_state = ST_RUN;
					end
				end
				ST_RUN: begin
					if (term_rise[T_BYPASS]) begin
						next_state = ST_BYPASS;
					end else if (!run_cmd) begin
						next_state = ST_STOP;
					end
				end
				ST_BYPASS: begin
					if (term_fall[T_BYPASS]) begin
						next_state = ST_RETRY;
					end
				end
				ST_RETRY: begin
					if (retry_done) begin
						if (!run_cmd) begin
							next_state = ST_STOP;
						end else if (above_threshold) begin
							next_state = ST_MATCH;
						end else begin
							next_state = ST_RUN;
						end
					end
				end
				ST_MATCH: begin
					next_state = ST_RUN;
				end
				ST_TRIP: begin
					if (trip_code == THERMISTOR_TRIP_CODE) begin
						if (stop_reset_key_i && !therm_fault) begin
							next_state = ST_STOP;
							next_trip_code = TRIP_NONE;
						end
					end else if (stop_reset_key_i || !run_cmd) begin
						next_state = ST_STOP;
						next_trip_code = TRIP_NONE;
					end
				end
				default: begin
					next_state = ST_RESET;
					next_trip_code = TRIP_NONE;
				end
			endcase
		end
	end

	// Millisecond enable divider; the exact count is a parameter so benches can shorten it
	always_ff @(posedge clk_i) begin
		if (rst_i || ms_div == MS_LAST) begin
			ms_div <= '0;
		end else begin
			ms_div <= ms_div + MW'(1);
		end
		ms_tick <= !rst_i && ms_div == MS_LAST;
	end

	// Time spent in the current state, in milliseconds
	always_ff @(posedge clk_i) begin
		if (rst_i || next_state != state) begin
			state_ms <= '0;
		end else if (ms_tick && state_ms != 16'hFFFF) begin
			state_ms <= state_ms + 16'h0001;
		end
	end

	// State and trip code; power-on enters the same reset state as the terminal,
	// but the unattended-start check belongs only to the first reset after power-on
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= ST_RESET;
			trip_code <= TRIP_NONE;
			powerup_pending <= 1'b1;
		end else begin
			state <= next_state;
			trip_code <= next_trip_code;
			if (state == ST_RESET && next_state != ST_RESET) begin
				powerup_pending <= 1'b0;
			end
		end
	end

	// Power-up watch of the reset terminal; a drop of the terminal, or the terminal open once the power-up reset is over, ends it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			powerup_window <= 1'b1;
			comm_ms <= '0;
		end else if (!powerup_window) begin
			comm_ms <= '0;
		end else if (term_fall[T_RESET] || (!powerup_pending && !reset_level)) begin
			powerup_window <= 1'b0;
		end else if (ms_tick && reset_level) begin
			comm_ms <= comm_ms + 13'h0001;
		end
	end

	// Communication fault shown to the remote operator, never a drive trip
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			comm_err <= 1'b0;
		end else if (powerup_window && reset_level && comm_ms > COMM_ERR_HOLD_MS) begin
			comm_err <= 1'b1;
		end else if (!reset_level && any_key_i) begin
			comm_err <= 1'b0;
		end
	end

	// Registered drive outputs; motor stays off while reset is held
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			motor_output_o <= 1'b0;
			run_mode_o <= 1'b0;
			freq_match_o <= 1'b0;
			alarm_o <= 1'b0;
			trip_code_o <= TRIP_NONE;
			comm_error_o <= 1'b0;
		end else begin
			motor_output_o <= (next_state == ST_RUN || next_state == ST_MATCH) &&
				!reset_level;
			run_mode_o <= next_state inside {ST_RUN, ST_BYPASS, ST_RETRY, ST_MATCH};
			freq_match_o <= next_state == ST_MATCH;
			alarm_o <= (next_state == ST_TRIP) && !reset_level;
			trip_code_o <= next_trip_code;
			comm_error_o <= comm_err;
		end
	end

	// Edit verdicts are one-cycle pulses answering each request cycle; analog selection outputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			edit_accept_o <= 1'b0;
			edit_reject_o <= 1'b0;
			analog_source_o <= SRC_NONE;
			range_4_20_o <= 1'b0;
			bipolar_enable_o <= 1'b0;
		end else begin
			edit_accept_o <= edit_req_i & edit_ok;
			edit_reject_o <= edit_req_i & ~edit_ok;
			analog_source_o <= next_source;
			range_4_20_o <= next_source == SRC_CURRENT;
			bipolar_enable_o <= next_bipolar;
		end
	end

	// Register writes land on the edge that raises ack
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			config_reg <= CONFIG_RESET;
			retry_delay_param <= RETRY_RESET;
			match_threshold_param <= THRESH_RESET;
		end else if (bus_wr) begin
			if (wb_adr_i == CONFIG_ADDR) begin
				config_reg <= write_word[8:0];
			end
			if (wb_adr_i == RETRY_ADDR) begin
				retry_delay_param <= write_word[15:0];
			end
			if (wb_adr_i == THRESH_ADDR) begin
				match_threshold_param <= write_word[15:0];
			end
		end
	end

	// Single-wait-state slave; unmapped addresses ack and read zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= bus_req;
			wb_dat_o <= bus_req ? read_word : 32'h00000000;
		end
	end
endmodule

/* File: include/drive_terminal_pkg.sv */
package drive_terminal_pkg;

	// Clock and timing base
	localparam int CLK_FREQ_HZ = 20_000_000;
	localparam int MS_TICK_CYCLES = CLK_FREQ_HZ / 1000;
	localparam int DEBOUNCE_TIME_US = 5000;
	localparam int DEBOUNCE_CYCLES = (CLK_FREQ_HZ / 1_000_000) * DEBOUNCE_TIME_US;
	localparam int RESET_MIN_PULSE_MS = 12;
	localparam int ALARM_CLEAR_MAX_MS = 30;
	localparam int RUN_AFTER_POWERUP_S = 3;
	localparam int COMM_ERR_HOLD_S = 4;
	localparam logic [12:0] COMM_ERR_HOLD_MS = 13'(COMM_ERR_HOLD_S * 1000);
	localparam logic [15:0] RESET_HOLD_MS = 16'h000A;

	// Register byte addresses
	localparam logic [7:0] CONFIG_ADDR = 8'h00;
	localparam logic [7:0] RETRY_ADDR = 8'h04;
	localparam logic [7:0] THRESH_ADDR = 8'h08;
	localparam logic [7:0] STATUS_ADDR = 8'h0C;

	// Configuration field positions
	localparam int CFG_LOCK_LSB = 0;
	localparam int CFG_PAIR_LSB = 2;
	localparam int CFG_BIPOLAR_LSB = 4;
	localparam int CFG_FSRC_LSB = 6;
	localparam int CFG_RESET_EDGE_BIT = 8;

	// Reset values
	localparam logic [8:0] CONFIG_RESET = 9'h000;
	localparam logic [15:0] RETRY_RESET = 16'h03E8;
	localparam logic [15:0] THRESH_RESET = 16'h0000;

	// Terminal bit positions in the debounced vector
	localparam int T_BYPASS = 0;
	localparam int T_LOCK = 1;
	localparam int T_ASEL = 2;
	localparam int T_RESET = 3;
	localparam int T_FWD = 4;
	localparam int T_REV = 5;
	localparam int T_TH_OVER = 6;
	localparam int T_TH_OPEN = 7;
	localparam int TERMINALS = 8;

	// Setting encodings
	localparam logic [1:0] PAIR_CURRENT = 2'h0;
	localparam logic [1:0] PAIR_SECOND_V = 2'h1;
	localparam logic [1:0] FSRC_ANALOG = 2'h1;
	localparam logic [1:0] BIPOLAR_OFF = 2'h0;

	typedef enum logic [1:0] {
		LOCK_TERM_ALL = 2'b00,
		LOCK_TERM_FREQ_FREE = 2'b01,
		LOCK_SOFT_ALL = 2'b10,
		LOCK_SOFT_FREQ_FREE = 2'b11
	} lock_scope_type;

	typedef enum logic [1:0] {
		SRC_PRIMARY_V = 2'b00,
		SRC_CURRENT = 2'b01,
		SRC_SECOND_V = 2'b10,
		SRC_NONE = 2'b11
	} source_type;

	typedef enum logic [2:0] {
		ST_RESET = 3'b000,
		ST_STOP = 3'b001,
		ST_RUN = 3'b010,
		ST_BYPASS = 3'b011,
		ST_RETRY = 3'b100,
		ST_MATCH = 3'b101,
		ST_TRIP = 3'b110
	} state_type;

	// Trip codes
	localparam logic [7:0] TRIP_NONE = 8'h00;
	localparam logic [7:0] UNATTENDED_START_CODE = 8'h0D;
	localparam logic [7:0] THERMISTOR_TRIP_CODE = 8'h23;

endpackage

/* File: hw/terminal_debounce.sv */
`timescale 1ns/10ps
module terminal_debounce #(
	parameter int WIDTH = 8,
	parameter int COUNT = 100000
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Raw terminals
	input wire logic [WIDTH-1:0] raw_i,
	// Filtered level and edge pulses
	output logic [WIDTH-1:0] level_o,
	output logic [WIDTH-1:0] rise_o,
	output logic [WIDTH-1:0] fall_o
);
	localparam int CW = $clog2(COUNT + 1);
	localparam logic [CW-1:0] LAST = CW'(COUNT - 1);

	logic [WIDTH-1:0] sync_a;
	logic [WIDTH-1:0] sync_b;
	logic [CW-1:0] cnt [WIDTH];

	// Two-stage synchroniser; first stage feeds only the second
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync_a <= '0;
			sync_b <= '0;
		end else begin
			sync_a <= raw_i;
			sync_b <= sync_a;
		end
	end

	// A level must hold a full window before it is accepted, so contact bounce
	// produces exactly one edge
	always_ff @(posedge clk_i) begin
		for (int i = 0; i < WIDTH; i++) begin
			if (rst_i) begin
				cnt[i] <= '0;
				level_o[i] <= 1'b0;
				rise_o[i] <= 1'b0;
				fall_o[i] <= 1'b0;
			end else begin
				rise_o[i] <= 1'b0;
				fall_o[i] <= 1'b0;
				if (sync_b[i] == level_o[i]) begin
					cnt[i] <= '0;
				end else if (cnt[i] == LAST) begin
					cnt[i] <= '0;
					level_o[i] <= sync_b[i];
					rise_o[i] <= sync_b[i];
					fall_o[i] <= ~sync_b[i];
				end else begin
					cnt[i] <= cnt[i] + CW'(1);
				end
			end
		end
	end
endmodule

/* File: dv/drive_terminal_asserts.sv */
`timescale 1ns/10ps
module drive_terminal_asserts
	import drive_terminal_pkg::*;
#(
	parameter int MS_CYCLES = 20,
	parameter int DEBOUNCE_COUNT = 4
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Register bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// Terminals and edit port
	input wire logic bypass_enable_in,
	input wire logic reset_in,
	input wire logic edit_req_i,
	input wire logic edit_accept_o,
	input wire logic edit_reject_o,
	// Drive outputs
	input wire logic motor_output_o,
	input wire logic run_mode_o,
	input wire logic freq_match_o,
	input wire logic alarm_o,
	input wire logic comm_error_o,
	input wire logic [1:0] analog_source_o,
	input wire logic range_4_20_o,
	input wire logic bipolar_enable_o
);
	// Margin past the debounce delay before a held contact must have acted
	localparam int SETTLE = DEBOUNCE_COUNT + 10;
	logic [7:0] byp_cnt;
	logic [7:0] rsi_cnt;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// How long each contact has stayed closed; saturates so it never wraps
	always_ff @(posedge clk_i) begin
		byp_cnt <= (rst_i || !bypass_enable_in) ? 8'h00 : byp_cnt + 8'(byp_cnt != 8'hFF);
		rsi_cnt <= (rst_i || !reset_in) ? 8'h00 : rsi_cnt + 8'(rsi_cnt != 8'hFF);
	end
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held too long");
	a_ack_answers: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered");
	a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
		else $error("read data outside ack");
	a_edit_one_answer: assert property (edit_req_i |=> edit_accept_o != edit_reject_o)
		else $error("edit answer missing or doubled");
	a_edit_no_stray: assert property (!edit_req_i |=> !(edit_accept_o || edit_reject_o))
		else $error("edit answer without request");
	a_bypass_mutes: assert property (byp_cnt >= SETTLE |-> !motor_output_o)
		else $error("motor driven during bypass");
	a_trip_stops_motor: assert property (alarm_o |-> !motor_output_o)
		else $error("motor driven while tripped");
	a_reset_quiets: assert property (rsi_cnt >= SETTLE |-> !alarm_o && !motor_output_o)
		else $error("alarm or motor during reset");
	a_range_current: assert property (range_4_20_o == (analog_source_o == SRC_CURRENT))
		else $error("range flag disagrees with source");
	a_current_unipolar: assert property (
		analog_source_o == SRC_CURRENT |-> !bipolar_enable_o)
		else $error("current loop made bipolar");
	a_match_in_run: assert property (freq_match_o |-> run_mode_o ##1 !freq_match_o)
		else $error("match pulse outside run");
	a_comm_no_fault: assert property ($rose(comm_error_o) |-> !alarm_o)
		else $error("comm error with fault");
endmodule
bind drive_input_terminal_functions drive_terminal_asserts #(
	.MS_CYCLES(MS_CYCLES),
	.DEBOUNCE_COUNT(DEBOUNCE_COUNT)
) u_asserts (.*);

/* File: dv/terminal_switches.sv */
`timescale 1ns/10ps
module terminal_switches
	import drive_terminal_pkg::*;
#(
	parameter int MS_CYCLES = 20
) (
	// Clock and power-up reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Contacts on the terminals
	output logic bypass_enable_in,
	output logic edit_lock_in,
	output logic analog_select_in,
	output logic reset_in,
	output logic forward_run_in,
	output logic reverse_run_in,
	output logic thermistor_in,
	output logic thermistor_open_i
);
	logic [TERMINALS-1:0] sw;
	int up_cyc = 0;
	// The reset contact is already closed when power comes up
	initial begin
		sw = 8'h00;
		sw[T_RESET] = 1'b1;
	end
	// Contacts are plain levels with no float
	assign bypass_enable_in = sw[T_BYPASS];
	assign edit_lock_in = sw[T_LOCK];
	assign analog_select_in = sw[T_ASEL];
	assign reset_in = sw[T_RESET];
	assign forward_run_in = sw[T_FWD];
	assign reverse_run_in = sw[T_REV];
	assign thermistor_in = sw[T_TH_OVER];
	assign thermistor_open_i = sw[T_TH_OPEN];
	// Time since power-up gates the run contact
	always @(posedge clk_i) up_cyc <= rst_i ? 0 : up_cyc + 1;
	task automatic set_sw(input int idx, input logic v);
		@(posedge clk_i);
		sw[idx] <= v;
	endtask
	// A run stays off until 3 s after power-up; one left on is not withdrawn
	task automatic set_run(input logic v);
		while (v && up_cyc < RUN_AFTER_POWERUP_S * 1000 * MS_CYCLES) @(posedge clk_i);
		set_sw(T_FWD, v);
	endtask
	// Held the full minimum width so the drive cannot miss it
	task automatic pulse_reset();
		set_sw(T_RESET, 1'b1);
		repeat (RESET_MIN_PULSE_MS * MS_CYCLES) @(posedge clk_i);
		sw[T_RESET] <= 1'b0;
	endtask
endmodule

/* File: dv/drive_input_terminal_functions_test.sv */
`timescale 1ns/10ps
module drive_input_terminal_functions_test;
	import drive_terminal_pkg::*;
	// Short ms tick and debounce keep the run brief
	localparam int MS = 4;
	localparam int DB = 4;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'hF;
	logic [31:0] wb_dat_i = 32'h00000000;
	logic [31:0] wb_dat_o, rd;
	logic stop_reset_key_i = 1'b0, any_key_i = 1'b0, edit_req_i = 1'b0, edit_is_freq_i = 1'b0;
	logic [15:0] motor_freq_i = 16'h0000;
	logic bypass_enable_in, edit_lock_in, analog_select_in, reset_in, forward_run_in;
	logic reverse_run_in, thermistor_in, thermistor_open_i, wb_ack_o, edit_accept_o;
	logic edit_reject_o, motor_output_o, run_mode_o, freq_match_o, alarm_o, comm_error_o;
	logic range_4_20_o, bipolar_enable_o;
	logic [7:0] trip_code_o;
	logic [1:0] analog_source_o;
	int n_errors = 0;
	int checked = 0;
	int i, j, k, cnt;
	always #25 clk_i = ~clk_i;
	terminal_switches #(.MS_CYCLES(MS)) u_sw (.*);
	drive_input_terminal_functions #(.MS_CYCLES(MS), .DEBOUNCE_COUNT(DB)) u_dut (.*);
	task automatic check(input string what, input logic [31:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// One classic cycle; read data is taken at the ack edge
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task automatic edit(input logic f, input logic rej);
		@(posedge clk_i);
		edit_req_i <= 1'b1;
		edit_is_freq_i <= f;
		@(posedge clk_i);
		edit_req_i <= 1'b0;
		@(posedge clk_i);
		check("edit answer", {edit_accept_o, edit_reject_o}, {!rej, rej});
	endtask
	task automatic key();
		@(posedge clk_i);
		stop_reset_key_i <= 1'b1;
		@(posedge clk_i);
		stop_reset_key_i <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask
	task automatic end_sim();
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// Cuts a hang short well past the expected length of the run
	initial begin
		repeat (45000) @(posedge clk_i);
		n_errors++;
		end_sim();
	end
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b1, 8'h10, 32'hFFFFFFFF);
		wb(1'b0, 8'h10, 32'h0);
		check("hole", rd, 32'h0);
		wb(1'b0, RETRY_ADDR, 32'h0);
		check("retry reset", rd, 32'(RETRY_RESET));
		check("no analog", analog_source_o, 2'b11);
		// Reset contact closed since power-up: comm error only after 4 s
		repeat ((COMM_ERR_HOLD_S * 1000 - 20) * MS) @(posedge clk_i);
		check("comm early", comm_error_o, 1'b0);
		repeat (40 * MS) @(posedge clk_i);
		check("comm set", {comm_error_o, alarm_o}, 2'b10);
		u_sw.set_sw(T_RESET, 1'b0);
		repeat (20) @(posedge clk_i);
		any_key_i <= 1'b1;
		@(posedge clk_i);
		any_key_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		check("comm clear", comm_error_o, 1'b0);
		// Select off and on with pair 00 and 01, bipolar mode on
		for (i = 0; i < 4; i++) begin
			u_sw.set_sw(T_ASEL, i[1]);
			wb(1'b1, CONFIG_ADDR, 32'h50 | (32'(i[0]) << 2));
			repeat (12) @(posedge clk_i);
			k = i[1] ? (i[0] ? 2 : 1) : 0;
			check("source", {analog_source_o, range_4_20_o}, {2'(k), k == 1});
			check("bipolar", bipolar_enable_o, k != 1);
		end
		wb(1'b1, CONFIG_ADDR, 32'h14);
		repeat (3) @(posedge clk_i);
		check("source off", analog_source_o, 2'b11);
		// Every lock scope, terminal level and edit target
		for (i = 0; i < 16; i++) begin
			wb(1'b1, CONFIG_ADDR, 32'(i[1:0]));
			u_sw.set_sw(T_LOCK, i[2]);
			repeat (10) @(posedge clk_i);
			edit(i[3], (i[1] | i[2]) & !(i[3] & i[0]));
		end
		u_sw.set_sw(T_LOCK, 1'b0);
		// Bypass handover, once above and once below the match threshold
		wb(1'b1, RETRY_ADDR, 32'h5);
		wb(1'b1, THRESH_ADDR, 32'h64);
		u_sw.set_run(1'b1);
		for (j = 0; j < 2; j++) begin
			motor_freq_i <= j ? 16'h0032 : 16'h00C8;
			u_sw.set_sw(T_BYPASS, 1'b1);
			// Held long enough for the bypass assertion to look at a settled contact
			repeat (20) @(posedge clk_i);
			check("bypass", {motor_output_o, run_mode_o}, 2'b01);
			u_sw.set_sw(T_BYPASS, 1'b0);
			cnt = 0;
			k = 0;
			for (i = 0; i < 200; i++) begin
				@(posedge clk_i);
				k += int'(freq_match_o === 1'b1);
				if (motor_output_o === 1'b1 && cnt == 0) cnt = i;
			end
			check("match", k, j ? 0 : 1);
			check("retry wait", cnt >= DB + 2 + 5 * MS, 1'b1);
			check("resumed", motor_output_o, 1'b1);
		end
		// Over-temperature and open circuit trips; key, leading and trailing reset clear
		for (j = 0; j < 3; j++) begin
			k = (j == 1) ? T_TH_OPEN : T_TH_OVER;
			wb(1'b1, CONFIG_ADDR, (j == 2) ? 32'h100 : 32'h0);
			u_sw.set_sw(k, 1'b1);
			repeat (12) @(posedge clk_i);
			check("trip", {alarm_o, motor_output_o, trip_code_o},
				{2'b10, THERMISTOR_TRIP_CODE});
			key();
			check("hot key", alarm_o, 1'b1);
			u_sw.set_sw(k, 1'b0);
			repeat (12) @(posedge clk_i);
			if (j == 0) begin
				key();
			end else fork
				u_sw.pulse_reset();
				begin
					cnt = 0;
					while (alarm_o !== 1'b0 && cnt < 200) begin
						@(posedge clk_i);
						cnt++;
					end
					check("alarm drop", cnt < 30 * MS, 1'b1);
					repeat (4) @(posedge clk_i);
					wb(1'b0, STATUS_ADDR, 32'h0);
					check("edge state", rd[2:0], (j == 2) ? 3'h6 : 3'h0);
				end
			join
			repeat (30 * MS) @(posedge clk_i);
			check("cleared", {alarm_o, trip_code_o}, 9'h000);
		end
		// Power-on with run already closed must not start
		rst_i <= 1'b1;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat ((RESET_HOLD_MS + 2) * MS + 20) @(posedge clk_i);
		check("usp", {alarm_o, trip_code_o}, {1'b1, UNATTENDED_START_CODE});
		u_sw.set_run(1'b0);
		repeat (12) @(posedge clk_i);
		check("usp clear", alarm_o, 1'b0);
		u_sw.set_run(1'b1);
		repeat (20) @(posedge clk_i);
		check("late run", run_mode_o, 1'b1);
		end_sim();
	end
endmodule
